/* aomsel_top.sv */
/*
 output port and mode select logic of a 16-bit sampling converter.
 holds the configuration registers, the output coding, the parallel bus,
 the serial shifter and the fastest-mode interval monitor.
 assumes conv_start_i / result_valid_i are one-cycle pulses on ref_clk_i
 and that data pins d7..d4 and the serial clock pin are resolved outside.
*/
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
// Function
// - high coding gives binary, low inverts msb
// - fast high, low-power low selects fastest mode
// - fast low keeps accuracy at any rate
// - low-power high, fast low: reduced power mode
// - port select picks parallel or serial port
// - data bits 0 to 3 always driven
// - bit 4 output, or serial clock source input
// - internal clock driven out, or external followed
// - bit 5 selects frame strobe polarity
// - bit 6 selects serial clock inversion
// - inversion swaps the referenced clock edge
// - bit 7 read mode or chain data input
// - result shifted out msb first, coded
// - external clock updates on active, valid next edge
`timescale 1ns/10ps
module aomsel_top
   import aomsel_pkg::*;
#(
   parameter int MAX_GAP_CYCLES = AOM_MAX_GAP_CYC  // cycles between fast conversions
)
(
   input wire logic ref_clk_i,                // 10 MHz clock
   input wire logic arst_n_i,                 // async reset, low
   // axi4-lite slave
   input wire logic [3:0] s_awaddr_i,         // write address
   input wire logic s_awvalid_i,              // write address valid
   output logic s_awready_o,                  // write address ready
   input wire logic [31:0] s_wdata_i,         // write data
   input wire logic [3:0] s_wstrb_i,          // write strobes
   input wire logic s_wvalid_i,               // write data valid
   output logic s_wready_o,                   // write data ready
   output logic [1:0] s_bresp_o,              // write response
   output logic s_bvalid_o,                   // write response valid
   input wire logic s_bready_i,               // write response ready
   input wire logic [3:0] s_araddr_i,         // read address
   input wire logic s_arvalid_i,              // read address valid
   output logic s_arready_o,                  // read address ready
   output logic [31:0] s_rdata_o,             // read data
   output logic [1:0] s_rresp_o,              // read response
   output logic s_rvalid_o,                   // read data valid
   input wire logic s_rready_i,               // read data ready
   // converter core side
   input wire logic conv_start_i,             // conversion start pulse
   input wire logic result_valid_i,           // conversion done pulse
   input wire logic [15:0] result_i,          // raw straight-binary result
   output aom_mode_type speed_mode_o,         // speed/power mode to core
   // pins
   output logic [15:0] data_o,                // data bus outputs
   output logic [3:0] data_hi_oe_n_o,         // d7..d4 enables, low drives
   input wire logic [3:0] data_hi_i,          // d7..d4 pin levels
   output logic sclk_o,                       // serial clock drive
   output logic sclk_oe_n_o,                  // serial clock enable, low drives
   input wire logic sclk_i,                   // serial clock pin level
   output logic frame_strobe_o,               // frame strobe
   output logic serial_result_output_o        // serial data (also on d8)
);
   ////////////////////////////////////////////////////////////////////
   // registers and wires
   typedef enum logic [1:0]
   {
      aom_st_idle = 2'b01,                    // no frame
      aom_st_shift = 2'b10                    // frame in progress
   } aom_state_type;

   aom_cfg_type cfg_reg;                      // configuration
   logic gap_flag_reg;                        // sticky interval overrun
   logic [15:0] res_reg;                      // last coded result
   logic aw_hold_reg;                         // write address taken
   logic w_hold_reg;                          // write data taken
   logic [3:0] aw_addr_reg;                   // captured write address
   logic [31:0] w_data_reg;                   // captured write data
   logic [3:0] w_strb_reg;                    // captured strobes
   logic bvalid_reg;                          // write response pending
   logic [1:0] bresp_reg;                     // write response code
   logic rvalid_reg;                          // read data pending
   logic [1:0] rresp_reg;                     // read response code
   logic [31:0] rdata_reg;                    // read data
   logic [3:0] sel_s1_reg;                    // pin sync stage 1
   aom_sel_type sel_reg;                      // pin sync stage 2
   logic sclk_s1_reg;                         // sclk sync stage 1
   logic sclk_s2_reg;                         // sclk sync stage 2
   logic sclk_s3_reg;                         // previous synced level
   aom_state_type st_reg;                     // shifter state
   logic [15:0] sh_reg;                       // output shift register
   logic [4:0] cnt_reg;                       // bits updated so far
   logic sdo_reg;                             // serial data bit
   logic div_reg;                             // internal clock phase
   logic [31:0] gap_cnt_reg;                  // cycles since last start
   logic [15:0] data_reg;                     // parallel bus word

   ////////////////////////////////////////////////////////////////////
   // decode and selection
   wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire wr_cfg = do_write && (aw_addr_reg[3:2] == AOM_CFG_OFS[3:2]);
   wire wr_stat = do_write && (aw_addr_reg[3:2] == AOM_STAT_OFS[3:2]);
   wire wr_ok = wr_cfg || wr_stat || (aw_addr_reg[3:2] == AOM_RES_OFS[3:2]);
   wire rd_take = s_arvalid_i && !rvalid_reg;
   wire [1:0] rd_idx = s_araddr_i[3:2];
   wire gap_clear = wr_stat && w_strb_reg[0] && w_data_reg[AOM_STAT_GAP_BIT];
   wire fast_mode = cfg_reg.fast && !cfg_reg.lowp;
   wire lowp_mode = cfg_reg.lowp && !cfg_reg.fast;
   // both selects low (or both high) leaves normal, full-accuracy mode
   wire [15:0] coded = cfg_reg.coding ? result_i
                                      : {~result_i[15], result_i[14:0]};
   wire serial = cfg_reg.serial;
   wire ser_next = (wr_cfg && w_strb_reg[0]) ? w_data_reg[AOM_CFG_SER_BIT] : serial;
   // during-conversion read outputs the previous result from the start pulse
   wire int_start = sel_reg.rd_chain ? conv_start_i : result_valid_i;
   wire start_evt = serial && (st_reg == aom_st_idle)
                    && (sel_reg.ext_clk ? result_valid_i : int_start);
   // active external edge: rising normally, falling when inverted
   wire ext_rise = sclk_s2_reg && !sclk_s3_reg;
   wire ext_fall = !sclk_s2_reg && sclk_s3_reg;
   wire ext_upd = sel_reg.clk_inv ? ext_fall : ext_rise;
   // internal clock: data moves as the uninverted clock falls
   wire int_upd = div_reg;
   wire upd = (st_reg == aom_st_shift) && (sel_reg.ext_clk ? ext_upd : int_upd);
   // chain data fills behind the result only with an external clock
   wire chain_bit = sel_reg.ext_clk ? sel_reg.rd_chain : 1'b0;
   wire frame_act = (st_reg == aom_st_shift);
   wire [31:0] stat_word = {28'h0000000, gap_flag_reg, frame_act, speed_mode_o};
   wire [1:0] mode_bits = fast_mode ? aom_mode_fast :
                          lowp_mode ? aom_mode_lowp : aom_mode_normal;

   assign speed_mode_o = aom_mode_type'(mode_bits);
   assign s_awready_o = !aw_hold_reg;
   assign s_wready_o = !w_hold_reg;
   assign s_bvalid_o = bvalid_reg;
   assign s_bresp_o = bresp_reg;
   assign s_arready_o = !rvalid_reg;
   assign s_rvalid_o = rvalid_reg;
   assign s_rresp_o = rresp_reg;
   assign s_rdata_o = rdata_reg;
   // d7..d4 turn into inputs in serial mode
   assign data_hi_oe_n_o = {4{serial}};
   assign data_o = data_reg;
   // serial clock pin driven only with the internal source in serial mode
   assign sclk_oe_n_o = !(serial && !sel_reg.ext_clk);
   assign sclk_o = (frame_act && div_reg) ^ sel_reg.clk_inv;
   assign frame_strobe_o = (frame_act && serial) ^ sel_reg.strb_inv;
   assign serial_result_output_o = sdo_reg;

   ////////////////////////////////////////////////////////////////////
   // axi write channels: address and data taken in either order
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         if (s_awvalid_i && !aw_hold_reg)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_awaddr_i;
         end
         else if (do_write)
            aw_hold_reg <= 1'b0;
         if (s_wvalid_i && !w_hold_reg)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_wdata_i;
            w_strb_reg <= s_wstrb_i;
         end
         else if (do_write)
            w_hold_reg <= 1'b0;
      end
   end

   // write response, unmapped offsets answer slverr
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= AOM_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_ok ? AOM_RESP_OKAY : AOM_RESP_SLVERR;
      end
      else if (s_bready_i)
         bvalid_reg <= 1'b0;
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg <= AOM_RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end
      else if (rd_take)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= (rd_idx == 2'h3) ? AOM_RESP_SLVERR : AOM_RESP_OKAY;
         unique case (rd_idx)
            AOM_CFG_OFS[3:2]: rdata_reg <= {28'h0000000, cfg_reg};
            AOM_STAT_OFS[3:2]: rdata_reg <= stat_word;
            AOM_RES_OFS[3:2]: rdata_reg <= {16'h0000, res_reg};
            default: rdata_reg <= 32'h00000000;   // unmapped reads zero
         endcase
      end
      else if (s_rready_i)
         rvalid_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // configuration register; only the low byte lane carries fields
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cfg_reg <= aom_cfg_type'(AOM_CFG_RST);
      else if (wr_cfg && w_strb_reg[0])
         cfg_reg <= aom_cfg_type'(w_data_reg[3:0]);
   end

   // latest coded result, kept for both ports and readback
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         res_reg <= AOM_RES_RST;
      else if (result_valid_i)
         res_reg <= coded;
   end

   // parallel bus; follows the select being written, so d7..d4 clear on release
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         data_reg <= 16'h0000;
      else if (!ser_next)
         data_reg <= res_reg;
      else
         data_reg <= {res_reg[15:9], sdo_reg, 4'h0, res_reg[3:0]};
   end

   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for pin selects and the serial clock pin
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sel_s1_reg <= 4'h0;
         sel_reg <= aom_sel_type'(4'h0);
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_s3_reg <= 1'b0;
      end
      else
      begin
         sel_s1_reg <= data_hi_i;
         sel_reg <= aom_sel_type'(sel_s1_reg);
         sclk_s1_reg <= sclk_i;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // serial shifter: loads the coded word, msb leaves first
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_reg <= aom_st_idle;
         sh_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         sdo_reg <= 1'b0;
      end
      else
      begin
         unique case (st_reg)
            aom_st_idle:
            begin
               cnt_reg <= 5'h00;
               if (start_evt)
               begin
                  // after-conversion read takes the fresh word directly
                  sh_reg <= result_valid_i ? coded : res_reg;
                  st_reg <= aom_st_shift;
               end
            end
            aom_st_shift:
            begin
               if (!serial)
                  st_reg <= aom_st_idle;                            // port switched away
               else if (upd)
               begin
                  sdo_reg <= sh_reg[15];
                  sh_reg <= {sh_reg[14:0], chain_bit};
                  cnt_reg <= cnt_reg + 5'h01;
                  // one extra edge lets the host sample the last bit
                  if (cnt_reg == AOM_BITS)
                     st_reg <= aom_st_idle;
               end
            end
         endcase
      end
   end

   // internal serial clock: half the reference rate while a frame runs
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         div_reg <= 1'b0;
      else
         div_reg <= frame_act && !sel_reg.ext_clk && !div_reg;
   end

   ////////////////////////////////////////////////////////////////////
   // fastest-mode interval monitor; a set beats a same-cycle clear
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         gap_cnt_reg <= 32'h00000000;
         gap_flag_reg <= 1'b0;
      end
      else
      begin
         if (conv_start_i || !fast_mode)
            gap_cnt_reg <= 32'h00000000;
         else if (gap_cnt_reg != 32'hffffffff)
            gap_cnt_reg <= gap_cnt_reg + 32'h00000001;
         // accuracy loss is only flagged; the core keeps converting
         if (fast_mode && conv_start_i && (gap_cnt_reg >= 32'(MAX_GAP_CYCLES)))
            gap_flag_reg <= 1'b1;
         else if (gap_clear)
            gap_flag_reg <= 1'b0;
      end
   end
endmodule

/* aomsel_pkg.sv */
/*
 converter output port and mode select: shared constants and types.
 assumes a 10 MHz reference clock and a 32-bit AXI4-Lite register bus.
*/
package aomsel_pkg;
   ////////////////////////////////////////////////////////////////////
   // register map (byte offsets)
   localparam logic [3:0] AOM_CFG_OFS = 4'h0;    // config register
   localparam logic [3:0] AOM_STAT_OFS = 4'h4;   // status register
   localparam logic [3:0] AOM_RES_OFS = 4'h8;    // last coded result
   // config field positions
   localparam int AOM_CFG_CODING_BIT = 0;        // 1 = straight binary
   localparam int AOM_CFG_FAST_BIT = 1;          // fastest-mode select
   localparam int AOM_CFG_LOWP_BIT = 2;          // low-power select
   localparam int AOM_CFG_SER_BIT = 3;           // 1 = serial port
   // status field positions
   localparam int AOM_STAT_MODE_LSB = 0;         // speed mode, 2 bits
   localparam int AOM_STAT_BUSY_BIT = 2;         // serial frame running
   localparam int AOM_STAT_GAP_BIT = 3;          // sticky interval overrun
   // reset values
   localparam logic [3:0] AOM_CFG_RST = 4'h1;    // straight binary, normal, parallel
   localparam logic [15:0] AOM_RES_RST = 16'h0000;
   // axi response codes
   localparam logic [1:0] AOM_RESP_OKAY = 2'b00;
   localparam logic [1:0] AOM_RESP_SLVERR = 2'b10;
   // timing
   localparam int AOM_CLK_KHZ = 10000;           // reference clock rate
   localparam int AOM_MAX_GAP_US = 1000;         // longest interval, fast mode
   localparam int AOM_MAX_GAP_CYC = AOM_MAX_GAP_US * AOM_CLK_KHZ / 1000;
   localparam logic [4:0] AOM_BITS = 5'h10;      // result bits per frame

   // speed/power modes handed to the converter core
   typedef enum logic [1:0]
   {
      aom_mode_normal = 2'h0,
      aom_mode_fast = 2'h1,
      aom_mode_lowp = 2'h2
   } aom_mode_type;

   // static configuration word
   typedef struct packed
   {
      logic serial;   // serial port selected
      logic lowp;     // low-power select
      logic fast;     // fastest-mode select
      logic coding;   // straight binary when high
   } aom_cfg_type;

   // pin-borne serial selects after synchronising
   typedef struct packed
   {
      logic rd_chain; // read mode (int clk) or chain data (ext clk)
      logic clk_inv;  // serial clock invert
      logic strb_inv; // frame strobe active low
      logic ext_clk;  // external serial clock
   } aom_sel_type;
endpackage

/* aomsel_monitor.sv */
/*
 concurrent checks on the ports of the output port and mode select block.
 assumes one clock domain on ref_clk_i with async active-low arst_n_i.
*/
`timescale 1ns/10ps
module aomsel_monitor
   import aomsel_pkg::*;
#(
   parameter int MAX_GAP_CYCLES = AOM_MAX_GAP_CYC  // kept equal to the design
)
(
   input wire logic ref_clk_i,          // clock
   input wire logic arst_n_i,           // reset, low
   input wire logic [3:0] s_awaddr_i,   // write address
   input wire logic s_awvalid_i,        // write address valid
   input wire logic s_awready_o,        // write address ready
   input wire logic s_wvalid_i,         // write data valid
   input wire logic s_wready_o,         // write data ready
   input wire logic [1:0] s_bresp_o,    // write response
   input wire logic s_bvalid_o,         // write response valid
   input wire logic s_bready_i,         // write response ready
   input wire logic [3:0] s_araddr_i,   // read address
   input wire logic s_arvalid_i,        // read address valid
   input wire logic s_arready_o,        // read address ready
   input wire logic [31:0] s_rdata_o,   // read data
   input wire logic [1:0] s_rresp_o,    // read response
   input wire logic s_rvalid_o,         // read valid
   input wire logic s_rready_i,         // read ready
   input wire logic result_valid_i,     // result pulse
   input wire logic [15:0] result_i,    // raw result
   input wire logic [15:0] data_o,      // data bus
   input wire logic [3:0] data_hi_oe_n_o, // d7..d4 enables
   input wire logic sclk_oe_n_o         // serial clock enable
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   ////////////////////////////////////////////////////////////////////
   // bus sequences
   sequence s_wr_both;
      s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
   endsequence
   sequence s_par_res;
      result_valid_i && data_hi_oe_n_o == 4'h0 ##2 data_hi_oe_n_o == 4'h0;
   endsequence
   property p_bhold;
      s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o);
   endproperty
   property p_rhold;
      s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o);
   endproperty
   property p_wr_okay;
      (s_wr_both ##0 s_awaddr_i != 4'hc) |-> ##[1:3] (s_bvalid_o && s_bresp_o == AOM_RESP_OKAY);
   endproperty
   property p_wr_unmapped;
      (s_wr_both ##0 s_awaddr_i == 4'hc) |-> ##[1:3] (s_bvalid_o && s_bresp_o == AOM_RESP_SLVERR);
   endproperty
   property p_rd_unmapped;
      s_arvalid_i && s_arready_o && s_araddr_i == 4'hc
         |=> s_rvalid_o && s_rresp_o == AOM_RESP_SLVERR && s_rdata_o == 32'h0;
   endproperty
   // d7..d4 either all driven (parallel) or all released with zero data
   property p_oe;
      data_hi_oe_n_o == 4'hf ? data_o[7:4] == 4'h0 : data_hi_oe_n_o == 4'h0;
   endproperty
   // the internal serial clock only leaves the pin in serial operation
   property p_sclk_oe;
      !sclk_oe_n_o |-> data_hi_oe_n_o == 4'hf;
   endproperty
   // msb depends on coding, the other bits pass straight through
   property p_par_data;
      s_par_res |-> data_o[14:0] == $past(result_i[14:0], 2);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
   a_wr_okay: assert property (p_wr_okay) else $error("write not answered");
   a_wr_unmapped: assert property (p_wr_unmapped) else $error("no write error");
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("no read error");
   a_oe: assert property (p_oe) else $error("d7..d4 drive wrong");
   a_sclk_oe: assert property (p_sclk_oe) else $error("sclk driven in parallel");
   a_par_data: assert property (p_par_data) else $error("parallel data wrong");
endmodule

bind aomsel_top aomsel_monitor #(.MAX_GAP_CYCLES(MAX_GAP_CYCLES)) aomsel_monitor_i (
   .ref_clk_i, .arst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wvalid_i,
   .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
   .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .result_valid_i,
   .result_i, .data_o, .data_hi_oe_n_o, .sclk_oe_n_o);

/* aomsel_host.sv */
/*
 host model: resolves d7..d4 and the serial clock pin, clocks frames, collects bits.
 assumes sel_i is static while a frame runs.
*/
`timescale 1ns/10ps
module aomsel_host
(
   input wire logic [3:0] sel_i,        // host levels for d7..d4
   input wire logic [3:0] oe_n_i,       // device enables for d7..d4
   input wire logic [3:0] dev_d_i,      // device data on d7..d4
   output logic [3:0] pin_o,            // resolved d7..d4
   input wire logic sclk_dev_i,         // device serial clock
   input wire logic sclk_oe_n_i,        // device clock enable, low drives
   output logic sclk_pin_o,             // resolved serial clock
   input wire logic strobe_i,           // frame strobe
   input wire logic sdo_i,              // serial data
   output logic [15:0] word_o,          // collected word
   output logic [4:0] nbits_o           // bits collected
);
   logic raw_clk = 1'b0; // host clock before inversion, low outside frames
   logic act, act_q; // strobe at its active level, and as the sampler last saw it
   assign pin_o = (oe_n_i & sel_i) | (~oe_n_i & dev_d_i);
   assign act = strobe_i ^ sel_i[1];
   assign sclk_pin_o = sclk_oe_n_i ? (raw_clk ^ sel_i[2]) : sclk_dev_i;
   ////////////////////////////////////////////////////////////////////
   // 800 ns external clock, seventeen periods
   always
   begin
      wait (act && sel_i[0] && sclk_oe_n_i === 1'b1);
      #400; // a select change flips act for a few ref cycles only
      if (act)
         repeat (17)
         begin
            #400 raw_clk = 1'b1;
            #400 raw_clk = 1'b0;
         end
      wait (!act);
   end
   // new frame clears the count; ext clock sampled falling, internal rising
   always @(act or (sclk_pin_o ^ sel_i[2]))
   begin
      if (act && !act_q)
         nbits_o = 5'h0;
      else if (act && ((sclk_pin_o ^ sel_i[2]) == !sel_i[0]))
      begin
         word_o = {word_o[14:0], sdo_i};
         if (nbits_o != 5'h10)
            nbits_o = nbits_o + 5'h1;
      end
      act_q = act;
   end
endmodule

/* test_aomsel_top.sv */
/*
 self-checking bench for the output port and mode select block.
 assumes the design package and the host model are compiled first.
*/
`timescale 1ns/10ps
module test_aomsel_top
   import aomsel_pkg::*;
;
   logic ref_clk_i = 1'b0, arst_n_i = 1'b0;
   logic [3:0] s_awaddr_i = 4'h0, s_araddr_i = 4'h0, s_wstrb_i = 4'hf, sel = 4'h0;
   logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
   logic s_arvalid_i = 1'b0, s_rready_i = 1'b0;
   logic [31:0] s_wdata_i = 32'h0;
   logic conv_start_i = 1'b0, result_valid_i = 1'b0;
   logic [15:0] result_i = 16'h0;
   logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
   logic [1:0] s_bresp_o, s_rresp_o;
   logic [31:0] s_rdata_o, rd;
   aom_mode_type speed_mode_o;
   logic [15:0] data_o, word;
   logic [3:0] data_hi_oe_n_o, data_hi_i;
   logic sclk_o, sclk_oe_n_o, sclk_i, frame_strobe_o, serial_result_output_o;
   logic [4:0] nbits;
   logic [1:0] rsp;
   int err_total = 0, n_checks = 0, i;
   always #50 ref_clk_i = ~ref_clk_i;
   aomsel_top #(.MAX_GAP_CYCLES(50)) aomsel_top_i (.*);
   aomsel_host aomsel_host_i (.sel_i(sel), .oe_n_i(data_hi_oe_n_o), .dev_d_i(data_o[7:4]),
      .pin_o(data_hi_i), .sclk_dev_i(sclk_o), .sclk_oe_n_i(sclk_oe_n_o),
      .sclk_pin_o(sclk_i), .strobe_i(frame_strobe_o), .sdo_i(serial_result_output_o),
      .word_o(word), .nbits_o(nbits));
   ////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // write: aw and w offered together
   task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ah, wh, bh;
      s_awaddr_i <= a; s_wdata_i <= d; s_awvalid_i <= 1'b1; s_wvalid_i <= 1'b1;
      s_bready_i <= 1'b1;
      bh = 1'b0;
      for (n = 0; n < 50 && !bh; n++)
      begin
         @(negedge ref_clk_i);
         ah = s_awvalid_i && s_awready_o; wh = s_wvalid_i && s_wready_o;
         bh = s_bvalid_o; rsp = s_bresp_o;
         @(posedge ref_clk_i);
         if (ah) s_awvalid_i <= 1'b0;
         if (wh) s_wvalid_i <= 1'b0;
      end
      s_bready_i <= 1'b0;
      chk({bh, rsp}, {1'b1, er});
   endtask
   task axr(input logic [3:0] a, input logic [1:0] er);
      int n;
      logic ah, rh;
      s_araddr_i <= a; s_arvalid_i <= 1'b1; s_rready_i <= 1'b1;
      rh = 1'b0;
      for (n = 0; n < 50 && !rh; n++)
      begin
         @(negedge ref_clk_i);
         ah = s_arvalid_i && s_arready_o; rh = s_rvalid_o; rd = s_rdata_o; rsp = s_rresp_o;
         @(posedge ref_clk_i);
         if (ah) s_arvalid_i <= 1'b0;
      end
      s_rready_i <= 1'b0;
      chk({rh, rsp}, {1'b1, er});
   endtask
   task pulse(input logic which, input logic [15:0] v);
      result_i <= v;
      if (which) result_valid_i <= 1'b1; else conv_start_i <= 1'b1;
      @(posedge ref_clk_i);
      result_valid_i <= 1'b0; conv_start_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////
   // reset values, unmapped and read-only places
   task t_regs;
      axr(AOM_CFG_OFS, AOM_RESP_OKAY); chk(rd, 32'h1);
      axr(4'hc, AOM_RESP_SLVERR); chk(rd, 32'h0);
      axw(4'hc, 32'h6, AOM_RESP_SLVERR);
      axw(AOM_RES_OFS, 32'h55, AOM_RESP_OKAY); axr(AOM_RES_OFS, AOM_RESP_OKAY);
      chk(rd, 32'h0);
   endtask
   // every select pair; both high falls back to normal
   task t_modes;
      logic [1:0] m [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      for (i = 0; i < 4; i++)
      begin
         axw(AOM_CFG_OFS, {29'h0, i[1:0], 1'b1}, AOM_RESP_OKAY);
         chk(speed_mode_o, m[i]);
         axr(AOM_STAT_OFS, AOM_RESP_OKAY); chk(rd[1:0], m[i]);
      end
   endtask
   // parallel word in both codings
   task t_par(input logic c);
      axw(AOM_CFG_OFS, {31'h0, c}, AOM_RESP_OKAY);
      pulse(1'b1, 16'h8123);
      chk(data_o, {c, 15'h0123});
      chk(data_hi_oe_n_o, 4'h0);
      axr(AOM_RES_OFS, AOM_RESP_OKAY); chk(rd, {c, 15'h0123});
   endtask
   // one serial frame with the given host selects and coding
   task t_ser(input logic [3:0] s, input logic c);
      int n;
      sel <= s;
      axw(AOM_CFG_OFS, {28'h0, 3'h4, c}, AOM_RESP_OKAY);
      repeat (5) @(posedge ref_clk_i);
      chk(data_hi_oe_n_o, 4'hf);
      chk(sclk_oe_n_o, s[0]);
      chk(frame_strobe_o, s[1]);
      chk(sclk_i, s[2]);
      pulse(1'b1, 16'hb4c1);
      for (n = 0; n < 400 && frame_strobe_o !== s[1]; n++) @(posedge ref_clk_i);
      chk({nbits, word}, {5'h10, c, 15'h34c1});
      chk(data_o[3:0], 4'h1);
   endtask
   // fast-mode interval monitor: short gap clean, long gap flagged
   task t_gap;
      sel <= 4'h0;
      axw(AOM_CFG_OFS, 32'h3, AOM_RESP_OKAY);
      pulse(1'b0, 16'h0);
      axw(AOM_STAT_OFS, 32'h8, AOM_RESP_OKAY);
      pulse(1'b0, 16'h0);
      axr(AOM_STAT_OFS, AOM_RESP_OKAY); chk(rd, 32'h1);
      repeat (60) @(posedge ref_clk_i);
      pulse(1'b0, 16'h0);
      axr(AOM_STAT_OFS, AOM_RESP_OKAY); chk(rd, 32'h9);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      t_regs;
      t_modes;
      t_par(1'b0);
      t_par(1'b1);
      t_ser(4'h0, 1'b1);
      t_ser(4'h6, 1'b0);
      t_ser(4'h3, 1'b1);
      t_ser(4'h5, 1'b0);
      t_gap;
      test_done;
   end
   // watchdog, far beyond the length of the run
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      test_done;
   end
endmodule
